// ---- cfg_pkg.sv ----
package cfg_pkg;

    // ------------------------------------------------------------------
    // Configuration word layout
    // ------------------------------------------------------------------
    localparam int unsigned WORD_W            = 32;
    localparam logic [31:0] WORD_RESET        = 32'h0000_03FF;
    localparam int unsigned POS_REF_VOLT      = 18;
    localparam int unsigned POS_READBACK      = 17;
    localparam int unsigned POS_FULL_UPDATE   = 16;
    localparam int unsigned POS_PD_C          = 15;
    localparam int unsigned POS_PD_B          = 14;
    localparam int unsigned POS_PD_A          = 13;
    localparam int unsigned POS_UNUSED        = 12;
    localparam int unsigned POS_CLK_SRC       = 11;
    localparam int unsigned POS_CLK_OUT       = 10;
    localparam int unsigned POS_DAC_MSB       = 9;
    localparam int unsigned DAC_W             = 10;
    localparam int unsigned POS_UPPER_LSB     = 24;
    localparam logic [31:0] UPPER_MASK        = 32'hFF00_0000;
    localparam int unsigned SER_BITS          = 32;
    localparam logic [5:0]  SER_LAST          = 6'h1F;

    // Decoded low-field controls handed to the analog side
    typedef struct packed {
        logic             ref_3v0;
        logic             readback_en;
        logic             full_update_enable;
        logic [2:0]       pair_powerdown;
        logic             conv_clock_source_select;
        logic             conv_clock_output_enable;
        logic [DAC_W-1:0] ref_dac_code;
    } low_ctrl_t;

endpackage : cfg_pkg

// ---- edge_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser with rise and fall pulses from the second stage
module edge_sync #(
    parameter logic IDLE = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    always_ff @(posedge clk) begin
        // Reset to the pin's idle level, else a false edge follows reset
        if (!rst_n) begin
            meta_r <= IDLE;
            sync_r <= IDLE;
            last_r <= IDLE;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise  = sync_r & ~last_r;
    assign fall  = ~sync_r & last_r;

endmodule : edge_sync
`default_nettype wire

// ---- converter_control.sv ----
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Bit 18 picks 2.5 V reference when clear, 3 V when set
// - Bit 17 set: next serial access shifts out the word
// - Serial writes touch only bits 31:24 unless bit 16 set
// - Bits 15,14,13 power down pairs C, B, A when set
// - Bit 12 unused: host writes zero, device holds zero
// - Bit 11 selects internal or external conversion clock, in software mode only
// - Bit 10 set with bit 11 clear drives internal clock onto shared pin, in software mode only
// - Bits 9:0 are reference DAC code, bit 9 MSB
// - Reference DAC code bits reset to one
// - Writes only in software mode, on strobe rise or 32nd fall
// - Word resets to 0x000003FF
module converter_control
    import cfg_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               mode_select_a,
    input  wire logic               wr_strobe_n,
    input  wire logic [31:0]        par_data,
    input  wire logic               sclk,
    input  wire logic               frame_n,
    input  wire logic               serial_data_in,
    input  wire logic               conv_clock_int,
    input  wire logic               conv_clock_pin_in,
    output var  cfg_pkg::low_ctrl_t ctrl,
    output logic [31:0]             converter_control_word,
    output logic                    serial_data_out_x,
    output logic                    conv_clock_pin_out,
    output logic                    conv_clock_pin_oe,
    output logic                    conv_clock_sel
);
    import cfg_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic mode_sw;
    logic wr_rise;
    logic sclk_fall;
    logic frame_lvl;
    logic sdi_lvl;
    logic ext_clk_lvl;
    logic m0_r, m1_r, sdi0_r, sdi1_r, pd0_r, pd1_r, cl0_r, cl1_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            m0_r   <= 1'b0;
            m1_r   <= 1'b0;
            sdi0_r <= 1'b0;
            sdi1_r <= 1'b0;
            cl0_r  <= 1'b0;
            cl1_r  <= 1'b0;
            pd0_r  <= 1'b0;
            pd1_r  <= 1'b0;
        end else begin
            m0_r   <= mode_select_a;
            m1_r   <= m0_r;
            sdi0_r <= serial_data_in;
            sdi1_r <= sdi0_r;
            cl0_r  <= conv_clock_pin_in;
            cl1_r  <= cl0_r;
            pd0_r  <= conv_clock_int;
            pd1_r  <= pd0_r;
        end
    end

    // High on the mode pin selects software mode
    assign mode_sw     = m1_r;
    assign sdi_lvl     = sdi1_r;
    assign ext_clk_lvl = cl1_r;

    edge_sync #(
        .IDLE  (1'b1)
    ) u_wr (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (wr_strobe_n),
        .level (),
        .rise  (wr_rise),
        .fall  ()
    );

    edge_sync u_sclk (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (sclk),
        .level (),
        .rise  (),
        .fall  (sclk_fall)
    );

    edge_sync #(
        .IDLE  (1'b1)
    ) u_frame (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (frame_n),
        .level (frame_lvl),
        .rise  (),
        .fall  ()
    );

    // Parallel data is stable around the strobe; delay it to line up
    logic [31:0] par0_r, par1_r, par2_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            par0_r <= '0;
            par1_r <= '0;
            par2_r <= '0;
        end else begin
            par0_r <= par_data;
            par1_r <= par0_r;
            par2_r <= par1_r;
        end
    end

    // ------------------------------------------------------------------
    // Serial shifter
    // ------------------------------------------------------------------
    logic [5:0]  bit_cnt_r;
    logic [31:0] shift_in_r;
    logic [31:0] shift_out_r;
    logic        readback_armed_r;
    logic        frame_active;
    logic        last_bit;
    logic [31:0] ser_word;

    assign frame_active = ~frame_lvl;
    assign last_bit     = frame_active & sclk_fall & (bit_cnt_r == SER_LAST);
    assign ser_word     = {shift_in_r[30:0], sdi_lvl};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bit_cnt_r <= '0;
        end else if (!frame_active) begin
            bit_cnt_r <= '0;
        end else if (sclk_fall && bit_cnt_r != SER_LAST) begin
            bit_cnt_r <= bit_cnt_r + 6'd1;
        end else if (sclk_fall) begin
            bit_cnt_r <= '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_in_r <= '0;
        end else if (frame_active && sclk_fall) begin
            shift_in_r <= ser_word;
        end
    end

    // ------------------------------------------------------------------
    // Configuration word
    // ------------------------------------------------------------------
    logic [31:0] word_r;
    logic [31:0] word_nxt;

    always_comb begin
        word_nxt = word_r;
        if (mode_sw && wr_rise) begin
            word_nxt = par2_r;
        end else if (mode_sw && last_bit) begin
            if (word_r[POS_FULL_UPDATE]) begin
                word_nxt = ser_word;
            end else begin
                word_nxt = (word_r & ~UPPER_MASK)
                         | (ser_word & UPPER_MASK);
            end
        end
        word_nxt[POS_UNUSED] = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word_r <= WORD_RESET;
        end else begin
            word_r <= word_nxt;
        end
    end

    // Read-back arms for the access after the one that set it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readback_armed_r <= 1'b0;
        end else if (!frame_active) begin
            readback_armed_r <= word_r[POS_READBACK];
        end
    end

    // Conversion results live elsewhere; zeros shift out otherwise
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_out_r <= '0;
        end else if (!frame_active) begin
            shift_out_r <= word_r[POS_READBACK] ? word_r : '0;
        end else if (sclk_fall) begin
            shift_out_r <= {shift_out_r[30:0], 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            serial_data_out_x <= 1'b0;
        end else begin
            serial_data_out_x <= readback_armed_r & shift_out_r[31];
        end
    end

    // ------------------------------------------------------------------
    // Decoded outputs
    // ------------------------------------------------------------------
    logic clk_src_eff;
    logic clk_out_eff;
    assign clk_src_eff = mode_sw & word_r[POS_CLK_SRC];
    assign clk_out_eff = mode_sw & word_r[POS_CLK_OUT];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl                   <= '0;
            ctrl.ref_dac_code      <= '1;
            converter_control_word <= WORD_RESET;
            conv_clock_pin_out     <= 1'b0;
            conv_clock_pin_oe      <= 1'b0;
            conv_clock_sel         <= 1'b0;
        end else begin
            ctrl.ref_3v0                  <= word_r[POS_REF_VOLT];
            ctrl.readback_en              <= word_r[POS_READBACK];
            ctrl.full_update_enable       <= word_r[POS_FULL_UPDATE];
            ctrl.pair_powerdown           <= word_r[POS_PD_C:POS_PD_A];
            ctrl.conv_clock_source_select <= clk_src_eff;
            ctrl.conv_clock_output_enable <= clk_out_eff;
            ctrl.ref_dac_code             <= word_r[POS_DAC_MSB:0];
            converter_control_word        <= word_r;
            // Output drive and external select are mutually exclusive
            conv_clock_pin_oe  <= clk_out_eff & ~clk_src_eff;
            conv_clock_pin_out <= clk_out_eff & ~clk_src_eff & pd1_r;
            conv_clock_sel     <= clk_src_eff & ext_clk_lvl;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        !word_r[POS_UNUSED]) else $error("unused bit set");
    AST_NO_WRITE_HW: assert property (@(posedge clk) disable iff (!rst_n)
        !mode_sw |=> $stable(word_r))
        else $error("word changed in hardware mode");
    AST_PARTIAL: assert property (@(posedge clk) disable iff (!rst_n)
        (last_bit && !wr_rise && !word_r[POS_FULL_UPDATE])
        |=> word_r[23:0] == $past(word_r[23:0]))
        else $error("partial update touched low bits");
    AST_FULL: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_sw && last_bit && !wr_rise && word_r[POS_FULL_UPDATE])
        |=> word_r[11:0] == $past(ser_word[11:0]))
        else $error("full update lost");
    AST_PAR: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_sw && wr_rise) |=> word_r[31:13] == $past(par2_r[31:13]))
        else $error("parallel write lost");
    AST_HW_CLK: assert property (@(posedge clk) disable iff (!rst_n)
        !mode_sw |=> !conv_clock_pin_oe && !conv_clock_sel)
        else $error("clock bits active in hardware mode");
    AST_PD: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> ctrl.pair_powerdown == $past(word_r[15:13]))
        else $error("powerdown mismatch");
    AST_DAC: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> ctrl.ref_dac_code == $past(word_r[9:0])
                 && ctrl.ref_3v0 == $past(word_r[18]))
        else $error("dac or vref mismatch");

endmodule : converter_control
`default_nettype wire

// ---- host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Host writing the configuration word
// ----------------------------------------------------------------
module host_model (
    input  wire logic   clk,
    input  wire logic   serial_data_out_x,
    output logic        wr_strobe_n,
    output logic [31:0] par_data,
    output logic        sclk,
    output logic        frame_n,
    output logic        serial_data_in,
    output logic [31:0] cap
);
    initial begin
        wr_strobe_n = 1'b1;
        par_data = 32'h0000_0000;
        sclk = 1'b0;
        frame_n = 1'b1;
        serial_data_in = 1'b0;
        cap = 32'h0000_0000;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : ticks

    // Write takes effect on the strobe rise
    task automatic par_write(input logic [31:0] d);
        ticks(1);
        par_data = d;
        wr_strobe_n = 1'b0;
        ticks(4);
        wr_strobe_n = 1'b1;
        ticks(4);
        // Released data must not look like the last value
        par_data = ~d;
        ticks(4);
    endtask : par_write

    // Short frames are dropped; read-back sampled before each fall
    task automatic ser_write(input logic [31:0] d, input int n);
        ticks(1);
        frame_n = 1'b0;
        cap = 32'h0000_0000;
        for (int i = 0; i < n; i++) begin
            serial_data_in = d[31-i];
            sclk = 1'b1;
            ticks(4);
            cap = {cap[30:0], serial_data_out_x};
            sclk = 1'b0;
            ticks(4);
        end
        ticks(4);
        frame_n = 1'b1;
        serial_data_in = ~serial_data_in;
        ticks(4);
    endtask : ser_write
endmodule : host_model
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Configuration word tests
// ----------------------------------------------------------------
module testbench;
    import cfg_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        mode_select_a;
    logic        conv_clock_int;
    logic        conv_clock_pin_in;
    logic        wr_strobe_n;
    logic [31:0] par_data;
    logic        sclk;
    logic        frame_n;
    logic        serial_data_in;
    logic [31:0] cap;
    low_ctrl_t   ctrl;
    logic [31:0] word;
    logic        sdo;
    logic        pin_out;
    logic        pin_oe;
    logic        clk_sel;
    int          fails;
    int          check_count;

    converter_control u_converter_control (
        .clk                    (clk),
        .rst_n                  (rst_n),
        .mode_select_a          (mode_select_a),
        .wr_strobe_n            (wr_strobe_n),
        .par_data               (par_data),
        .sclk                   (sclk),
        .frame_n                (frame_n),
        .serial_data_in         (serial_data_in),
        .conv_clock_int         (conv_clock_int),
        .conv_clock_pin_in      (conv_clock_pin_in),
        .ctrl                   (ctrl),
        .converter_control_word (word),
        .serial_data_out_x      (sdo),
        .conv_clock_pin_out     (pin_out),
        .conv_clock_pin_oe      (pin_oe),
        .conv_clock_sel         (clk_sel)
    );

    host_model u_host_model (
        .clk               (clk),
        .serial_data_out_x (sdo),
        .wr_strobe_n       (wr_strobe_n),
        .par_data          (par_data),
        .sclk              (sclk),
        .frame_n           (frame_n),
        .serial_data_in    (serial_data_in),
        .cap               (cap)
    );

    initial clk = 1'b0;
    always #25 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    // Whole run is about 1200 cycles
    initial begin
        repeat (8000) @(posedge clk);
        fails++;
        test_done();
    end

    initial begin
        fails = 0;
        check_count = 0;
        rst_n = 1'b0;
        mode_select_a = 1'b1;
        conv_clock_int = 1'b0;
        conv_clock_pin_in = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        u_host_model.ticks(3);
        check(word, WORD_RESET);
        check({14'h0, ctrl}, 32'h0000_03FF);
        check({30'h0, pin_oe, clk_sel}, 32'h0000_0000);
        $display("Test reset done");
        // Bit 12 written as one on purpose, pairs C and A powered down
        u_host_model.par_write(32'h0007_B3A5);
        check(word, 32'h0007_A3A5);
        check({14'h0, ctrl}, 32'h0003_D3A5);
        $display("Test parallel fields done");
        u_host_model.par_write(32'h0001_0400);
        check({31'h0, pin_oe}, 32'h0000_0001);
        check({14'h0, ctrl}, 32'h0000_8400);
        conv_clock_int = 1'b1;
        u_host_model.ticks(6);
        check({31'h0, pin_out}, 32'h0000_0001);
        conv_clock_int = 1'b0;
        u_host_model.ticks(6);
        check({31'h0, pin_out}, 32'h0000_0000);
        u_host_model.par_write(32'h0001_0800);
        conv_clock_pin_in = 1'b1;
        u_host_model.ticks(6);
        check({30'h0, pin_oe, clk_sel}, 32'h0000_0001);
        conv_clock_pin_in = 1'b0;
        u_host_model.ticks(6);
        check({31'h0, clk_sel}, 32'h0000_0000);
        $display("Test clock pin done");
        // Clock source cleared before leaving software mode
        u_host_model.par_write(32'h0001_0400);
        mode_select_a = 1'b0;
        conv_clock_pin_in = 1'b1;
        u_host_model.ticks(6);
        check({30'h0, pin_oe, clk_sel}, 32'h0000_0000);
        check({14'h0, ctrl}, 32'h0000_8000);
        u_host_model.par_write(32'h0000_0000);
        check(word, 32'h0001_0400);
        mode_select_a = 1'b1;
        conv_clock_pin_in = 1'b0;
        u_host_model.ticks(6);
        $display("Test hardware mode done");
        u_host_model.par_write(32'h0000_0000);
        u_host_model.ser_write(32'hA5FF_FFFF, 32);
        check(word, 32'hA500_0000);
        check(cap, 32'h0000_0000);
        u_host_model.ser_write(32'h1100_0000, 31);
        check(word, 32'hA500_0000);
        u_host_model.par_write(32'h0001_0000);
        u_host_model.ser_write(32'h0001_23FF, 32);
        check(word, 32'h0001_23FF);
        $display("Test serial update done");
        u_host_model.par_write(32'h0002_0000);
        u_host_model.ser_write(32'h0000_0000, 32);
        check(cap, 32'h0002_0000);
        check(word, 32'h0002_0000);
        $display("Test read-back done");
        test_done();
    end
endmodule : testbench
`default_nettype wire
